/* File: rtl/swrc_pkg.sv */
// Shared constants and types for the software reset control block
package swrc_pkg;

  // Register width and layout
  localparam int SWRC_REG_W = 16;
  localparam logic [15:0] SWRC_RESET_VAL = 16'h0000;
  // Writable bits; the four upper bits are reserved
  localparam logic [15:0] SWRC_WR_MASK = 16'h0FFF;

  // Field positions
  localparam int SWRC_OUT_RST_BIT = 11;
  localparam int SWRC_CFG_RST_BIT = 10;
  localparam int SWRC_DIG_RST_BIT = 9;
  localparam int SWRC_LOADER_BIT = 8;
  localparam int SWRC_OCSS_BIT = 7;
  localparam int SWRC_CONV_BIT = 6;
  localparam int SWRC_DPLL_BIT = 5;
  localparam int SWRC_MON_HI_BIT = 4;
  localparam int SWRC_MON_LO_BIT = 0;
  localparam int SWRC_NUM_MON = 5;

  // Width of the static configuration select pins
  localparam int SWRC_SEL_W = 3;
  // Reset value of the latched select pins
  localparam logic [2:0] SWRC_SEL_RESET = 3'h0;

  // Edges the driver reset is held after the bit clears
  localparam int SWRC_DRV_HOLD_CYC = 2;

  // Entry point of the restarted startup sequence
  typedef enum logic {
    SWRC_ENTRY_BIAS_CAL,
    SWRC_ENTRY_PIN_LATCH
  } swrc_entry_e;

  // Reset sequencing states
  typedef enum logic [1:0] {
    SWRC_IDLE,
    SWRC_WAIT_TXN,
    SWRC_FIRE
  } swrc_state_e;

endpackage

/* File: rtl/swrc_reset_ctrl.sv */
// Software reset control register with reset pulses and hold levels
// Notes on behaviour
// - Output driver bit holds drivers reset, disabled.
// - Driver reset asserts at once, may glitch.
// - Config reset clears all, restarts at bias.
// - Config reset writes ignored during startup.
// - Config reset never re-samples select pins.
// - Config-set reset reloads that same configuration.
// - Serial-set reset loads power-up latched selection.
// - Serial config reset waits for transaction end.
// - Digital reset clears all, restarts at latch.
// - Loader held reset while its bit set.
// - Overclock and spread held while bit set.
// - Converter PLL logic held while bit set.
// - Digital PLL held while its bit set.
// - Each monitor held by its own bit.
`timescale 1ns/10ps

module swrc_reset_ctrl
  import swrc_pkg::*;
(
  // System clock, 10 MHz
  input wire logic clk,
  // Asynchronous reset, active high
  input wire logic rst,
  // One-cycle register write strobe
  input wire logic reg_wr,
  // Register write data
  input wire logic [15:0] reg_wr_data,
  // High when the write comes from a user configuration
  input wire logic wr_from_config,
  // Index of the user configuration currently loading
  input wire logic [2:0] active_config_id,
  // Pulse at the end of a serial port write transaction
  input wire logic serial_txn_done,
  // High while the startup sequence runs
  input wire logic startup_busy,
  // Pulse from the sequencer at its pin latching step
  input wire logic pin_latch_step,
  // Static configuration select pins, asynchronous
  input wire logic [2:0] config_select_pins,
  // Register read data
  output logic [15:0] reg_rd_data,
  // Reset and disable for every clock output driver
  output logic output_driver_reset,
  // One-cycle pulse resetting all digital logic
  output logic digital_logic_reset,
  // One-cycle pulse restarting the startup sequence
  output logic restart_req,
  // Entry point of that restart
  output swrc_entry_e restart_entry,
  // User configuration to load on that restart
  output logic [2:0] restart_config,
  // Select pins as latched at the pin latching step
  output logic [2:0] latched_select,
  // Hold levels for the sub-blocks
  output logic config_loader_reset,
  output logic overclock_spread_reset,
  output logic converter_pll_logic_reset,
  output logic digital_pll_reset,
  output logic [4:0] monitor_reset
);

  // The register itself
  logic [15:0] reg_ff;
  logic [15:0] nxt_reg;
  // Sequencing state
  swrc_state_e state_ff;
  swrc_state_e nxt_state;
  // Pending reset is a digital reset (else config reset)
  logic kind_dig_ff;
  logic nxt_kind_dig;
  // Pending reset was written by a user configuration
  logic src_cfg_ff;
  logic nxt_src_cfg;
  // Configuration that wrote the pending reset
  logic [2:0] cfg_id_ff;
  logic [2:0] nxt_cfg_id;
  // Pin synchroniser and the stable pin value
  logic [2:0] pin_s1_ff;
  logic [2:0] pin_s2_ff;
  logic [2:0] pin_s3_ff;
  logic [2:0] pin_stable_ff;
  // Latched select pins
  logic [2:0] latched_ff;
  // Driver release hold chain
  logic [1:0] drv_hold_ff;
  // Registered restart outputs
  logic restart_ff;
  logic entry_bias_ff;
  logic [2:0] restart_cfg_ff;

  // Decode of the incoming write
  wire logic [15:0] wr_masked;
  wire logic cfg_wr_ok;
  wire logic cfg_req;
  wire logic dig_req;
  wire logic any_req;
  wire logic fire;
  wire logic [15:0] wr_value;

  // Reserved bits dropped from the written value
  // reserved writes dropped
  assign wr_masked = reg_wr_data & SWRC_WR_MASK;

  // Config reset writes count only outside startup
  // mask during startup
  assign cfg_wr_ok = ~startup_busy;

  // Config reset request from this write
  // config source accepted
  assign cfg_req = reg_wr & cfg_wr_ok & wr_masked[SWRC_CFG_RST_BIT];

  // Digital reset request from this write
  assign dig_req = reg_wr & wr_masked[SWRC_DIG_RST_BIT];

  // Either self-clearing reset requested
  assign any_req = cfg_req | dig_req;

  // Reset fires in the fire state only
  assign fire = (state_ff == SWRC_FIRE);

  // Written value, config bit kept while masked
  assign wr_value = cfg_wr_ok ? wr_masked :
    {wr_masked[15:11], reg_ff[SWRC_CFG_RST_BIT], wr_masked[9:0]};

  // Next register value
  always_comb begin
    nxt_reg = reg_ff;
    if (fire) begin
      nxt_reg = SWRC_RESET_VAL;
    end else if (reg_wr && (state_ff == SWRC_IDLE)) begin
      // Plain write while nothing pending
      nxt_reg = wr_value;
    end else if (reg_wr) begin
      // Pending reset: other fields still written
      nxt_reg = wr_value | (reg_ff & 16'h0600);
    end
  end

  // Sequencing of the self-clearing resets
  always_comb begin
    nxt_state = state_ff;
    nxt_kind_dig = kind_dig_ff;
    nxt_src_cfg = src_cfg_ff;
    nxt_cfg_id = cfg_id_ff;
    unique case (state_ff)
      // Wait for a reset request
      SWRC_IDLE: begin
        if (any_req) begin
          // Digital reset wins when both are set
          nxt_kind_dig = dig_req;
          nxt_src_cfg = wr_from_config;
          nxt_cfg_id = active_config_id;
          if (wr_from_config || serial_txn_done) begin
            nxt_state = SWRC_FIRE;
          end else begin
            nxt_state = SWRC_WAIT_TXN;
          end
        end
      end
      // Serial write still in progress
      SWRC_WAIT_TXN: begin
        if (serial_txn_done) begin
          nxt_state = SWRC_FIRE;
        end
      end
      // One cycle of reset and restart
      SWRC_FIRE: begin
        nxt_state = SWRC_IDLE;
      end
      // Unused code falls back to idle
      default: begin
        nxt_state = SWRC_IDLE;
      end
    endcase
  end

  // Register and sequencer state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_ff <= SWRC_RESET_VAL;
      state_ff <= SWRC_IDLE;
      kind_dig_ff <= 1'b0;
      src_cfg_ff <= 1'b0;
      cfg_id_ff <= SWRC_SEL_RESET;
    end else begin
      reg_ff <= nxt_reg;
      state_ff <= nxt_state;
      kind_dig_ff <= nxt_kind_dig;
      src_cfg_ff <= nxt_src_cfg;
      cfg_id_ff <= nxt_cfg_id;
    end
  end

  // Three-stage pin synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_ff <= SWRC_SEL_RESET;
      pin_s2_ff <= SWRC_SEL_RESET;
      pin_s3_ff <= SWRC_SEL_RESET;
    end else begin
      pin_s1_ff <= config_select_pins;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // Pin value counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_stable_ff <= SWRC_SEL_RESET;
    end else if (pin_s2_ff == pin_s3_ff) begin
      pin_stable_ff <= pin_s3_ff;
    end
  end

  // Pins latched only at the sequencer's latch step
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      latched_ff <= SWRC_SEL_RESET;
    end else if (pin_latch_step) begin
      latched_ff <= pin_stable_ff;
    end
  end

  // Restart pulse, entry point and configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      restart_ff <= 1'b0;
      entry_bias_ff <= 1'b0;
      restart_cfg_ff <= SWRC_SEL_RESET;
    end else begin
      restart_ff <= fire;
      if (fire) begin
        entry_bias_ff <= ~kind_dig_ff;
        restart_cfg_ff <= (src_cfg_ff && !kind_dig_ff) ? cfg_id_ff : latched_ff;
      end
    end
  end

  // Driver reset release chain, loaded with ones while the driver bit is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drv_hold_ff <= 2'h0;
    end else if (reg_ff[SWRC_OUT_RST_BIT]) begin
      drv_hold_ff <= 2'h3;
    end else begin
      drv_hold_ff <= {drv_hold_ff[0], 1'b0};
    end
  end

  assign output_driver_reset = reg_ff[SWRC_OUT_RST_BIT] | drv_hold_ff[SWRC_DRV_HOLD_CYC - 1];

  // Reset pulse to the digital logic
  // digital logic reset
  assign digital_logic_reset = restart_ff;
  assign restart_req = restart_ff;
  assign restart_entry = entry_bias_ff ? SWRC_ENTRY_BIAS_CAL : SWRC_ENTRY_PIN_LATCH;
  assign restart_config = restart_cfg_ff;
  assign latched_select = latched_ff;

  assign config_loader_reset = reg_ff[SWRC_LOADER_BIT];
  assign overclock_spread_reset = reg_ff[SWRC_OCSS_BIT];
  assign converter_pll_logic_reset = reg_ff[SWRC_CONV_BIT];
  assign digital_pll_reset = reg_ff[SWRC_DPLL_BIT];

  // One hold level per clock monitor
  // Monitor n sits n bits above the lowest monitor bit
  genvar gi;
  generate
    for (gi = 0; gi < SWRC_NUM_MON; gi++) begin : g_mon
      assign monitor_reset[gi] = reg_ff[SWRC_MON_LO_BIT + gi];
    end
  endgenerate

  // Read data, reserved bits zero
  // reserved read zero
  assign reg_rd_data = reg_ff & SWRC_WR_MASK;

endmodule

/* File: testbench/swrc_reset_ctrl_asserts.sv */
// Checker for the software reset control block
`timescale 1ns/10ps
module swrc_reset_ctrl_asserts
  import swrc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wr_data,
  input wire logic wr_from_config,
  input wire logic [2:0] active_config_id,
  input wire logic startup_busy,
  input wire logic [15:0] reg_rd_data,
  input wire logic output_driver_reset,
  input wire logic digital_logic_reset,
  input wire logic restart_req,
  input wire swrc_entry_e restart_entry,
  input wire logic [2:0] restart_config,
  input wire logic config_loader_reset,
  input wire logic overclock_spread_reset,
  input wire logic converter_pll_logic_reset,
  input wire logic digital_pll_reset,
  input wire logic [4:0] monitor_reset
);
  // All checks on the system clock, quiet during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Config reset written by a user configuration with nothing pending
  sequence s_cfg_wr;
    reg_wr && wr_from_config && reg_wr_data[10:9] == 2'b10 && !startup_busy
      && reg_rd_data[10:9] == 2'b00 && !digital_logic_reset;
  endsequence
  // Restart pulse two edges later, bias entry, same configuration
  sequence s_cfg_fire;
    ##2 digital_logic_reset && restart_entry == SWRC_ENTRY_BIAS_CAL
      && restart_config == $past(active_config_id, 2);
  endsequence
  property p_cfg_reset;
    s_cfg_wr |-> s_cfg_fire;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("config reset did not fire");
  property p_pulse;
    digital_logic_reset |-> restart_req && reg_rd_data == 16'h0000 ##1 !digital_logic_reset;
  endproperty
  a_pulse: assert property (p_pulse) else $error("reset pulse shape wrong");
  property p_masked;
    reg_wr && startup_busy && !reg_rd_data[10] |=> !reg_rd_data[10];
  endproperty
  a_masked: assert property (p_masked) else $error("config reset bit written while busy");
  property p_drv;
    reg_rd_data[11] |-> output_driver_reset;
  endproperty
  a_drv: assert property (p_drv) else $error("driver reset low while bit set");
  property p_drv_rel;
    $fell(reg_rd_data[11]) |-> output_driver_reset ##1 output_driver_reset
      ##1 (!output_driver_reset || reg_rd_data[11]);
  endproperty
  a_drv_rel: assert property (p_drv_rel) else $error("driver reset release wrong");
  property p_loader;
    config_loader_reset == reg_rd_data[8];
  endproperty
  a_loader: assert property (p_loader) else $error("loader hold mismatch");
  property p_ocss;
    overclock_spread_reset == reg_rd_data[7] && converter_pll_logic_reset == reg_rd_data[6];
  endproperty
  a_ocss: assert property (p_ocss) else $error("engine hold mismatch");
  property p_dpll;
    digital_pll_reset == reg_rd_data[5] && monitor_reset == reg_rd_data[4:0];
  endproperty
  a_dpll: assert property (p_dpll) else $error("pll or monitor hold mismatch");
  property p_rsv;
    reg_rd_data[15:12] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
endmodule
bind swrc_reset_ctrl swrc_reset_ctrl_asserts u_chk (.*);

/* File: testbench/test_software_reset_control.sv */
// Testbench for the software reset control block
`timescale 1ns/10ps
module test_software_reset_control;
  import swrc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic wr_from_config = 1'b0;
  logic serial_txn_done = 1'b0;
  logic startup_busy = 1'b0;
  logic pin_latch_step = 1'b0;
  logic [15:0] reg_wr_data = 16'h0000;
  logic [2:0] active_config_id = 3'h0;
  logic [2:0] config_select_pins = 3'h5;
  logic [15:0] reg_rd_data;
  logic output_driver_reset, digital_logic_reset, restart_req, config_loader_reset;
  logic overclock_spread_reset, converter_pll_logic_reset, digital_pll_reset;
  logic [4:0] monitor_reset;
  logic [2:0] restart_config, latched_select;
  swrc_entry_e restart_entry;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int i;
  always #50 clk = ~clk;
  swrc_reset_ctrl u_dut (.*);
  // Compare one value and count it
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  // One register write, returns with the new value settled
  task wr(input logic [15:0] d, input logic src, input logic [2:0] id);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_wr_data <= d;
    wr_from_config <= src;
    active_config_id <= id;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask
  // End of a serial write transaction
  task txn_end();
    @(posedge clk);
    serial_txn_done <= 1'b1;
    @(posedge clk);
    serial_txn_done <= 1'b0;
  endtask
  // Wait a bounded time for the restart pulse
  task wait_fire();
    for (int k = 0; k < 10 && digital_logic_reset !== 1'b1; k++) @(negedge clk);
    chk("pulse", 16'h1, 16'(digital_logic_reset));
  endtask
  task final_report();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("reset reg", SWRC_RESET_VAL, reg_rd_data);
    chk("reset entry", 16'(SWRC_ENTRY_PIN_LATCH), 16'(restart_entry));
    $display("reset test done");
    // Walk each hold bit; upper bits always written too
    for (i = 0; i <= 8; i++) begin
      wr(16'hF000 | 16'(1 << i), 1'b0, 3'h0);
      chk("reg", 16'(1 << i), reg_rd_data);
      chk("holds", 16'(1 << i), {7'h0, config_loader_reset, overclock_spread_reset,
        converter_pll_logic_reset, digital_pll_reset, monitor_reset});
    end
    // Converter logic and all monitors held across a reprogramming pass
    wr(16'h005F, 1'b0, 3'h0);
    chk("reprog", 16'h005F, reg_rd_data);
    chk("reprog holds", 16'h005F, {7'h0, config_loader_reset, overclock_spread_reset,
      converter_pll_logic_reset, digital_pll_reset, monitor_reset});
    wr(16'h0000, 1'b0, 3'h0);
    chk("reprog done", 16'h0000, reg_rd_data);
    $display("hold test done");
    wr(16'h0800, 1'b0, 3'h0);
    chk("drv on", 16'h1, 16'(output_driver_reset));
    wr(16'h0000, 1'b0, 3'h0);
    chk("drv hold", 16'h1, 16'(output_driver_reset));
    repeat (2) @(negedge clk);
    chk("drv off", 16'h0, 16'(output_driver_reset));
    $display("driver test done");
    // Latch select pins at the sequencer step
    repeat (5) @(posedge clk);
    pin_latch_step <= 1'b1;
    @(posedge clk);
    pin_latch_step <= 1'b0;
    config_select_pins <= 3'h2;
    repeat (5) @(negedge clk);
    chk("latched", 16'h5, 16'(latched_select));
    wr(16'h0400, 1'b1, 3'h6);
    wait_fire();
    chk("cfg entry", 16'(SWRC_ENTRY_BIAS_CAL), 16'(restart_entry));
    chk("cfg id", 16'h6, 16'(restart_config));
    @(negedge clk);
    chk("cleared", 16'h0, reg_rd_data);
    chk("no relatch", 16'h5, 16'(latched_select));
    $display("config reset test done");
    wr(16'h0400, 1'b0, 3'h3);
    repeat (3) begin
      @(negedge clk);
      chk("early", 16'h0, 16'(digital_logic_reset));
    end
    txn_end();
    wait_fire();
    chk("ser id", 16'h5, 16'(restart_config));
    $display("serial reset test done");
    wr(16'h0200, 1'b0, 3'h0);
    txn_end();
    wait_fire();
    chk("dig entry", 16'(SWRC_ENTRY_PIN_LATCH), 16'(restart_entry));
    $display("digital reset test done");
    @(posedge clk);
    startup_busy <= 1'b1;
    wr(16'h0420, 1'b0, 3'h0);
    chk("masked", 16'h0020, reg_rd_data);
    txn_end();
    repeat (4) @(negedge clk);
    chk("no fire", 16'h0, 16'(digital_logic_reset));
    $display("busy test done");
    final_report();
  end
endmodule
